/* File: design/tcep_axil.sv */
`timescale 1ns/1ps
module tcep_axil
  import tcep_pkg::*;
(
  input  wire logic          aclk,    // kernel clock
  input  wire logic          aresetn, // sync reset, low
  input  wire logic [AW-1:0] awaddr,  // write address
  input  wire logic          awvalid, // write address valid
  output      logic          awready, // write address ready
  input  wire logic [31:0]   wdata,   // write data
  input  wire logic [3:0]    wstrb,   // byte enables
  input  wire logic          wvalid,  // write data valid
  output      logic          wready,  // write data ready
  output      logic [1:0]    bresp,   // write answer
  output      logic          bvalid,  // write answer valid
  input  wire logic          bready,  // write answer ready
  input  wire logic [AW-1:0] araddr,  // read address
  input  wire logic          arvalid, // read address valid
  output      logic          arready, // read address ready
  output      logic [31:0]   rdata,   // read data
  output      logic [1:0]    rresp,   // read answer
  output      logic          rvalid,  // read data valid
  input  wire logic          rready,  // read data ready
  tcep_reg_if.bus            rif      // register file side
);
  typedef struct packed {
    logic          aw_v;
    logic [AW-1:0] aw_a;
    logic          w_v;
    logic [31:0]   w_d;
    logic [3:0]    w_s;
    logic          b_v;
    logic [1:0]    b_r;
    logic          r_v;
    logic [31:0]   r_d;
    logic [1:0]    r_r;
  } tcep_axs_t;

  tcep_axs_t q, d;
  logic      wr_fire;

  // hold address and data until both are in
  assign awready = !q.aw_v;
  assign wready  = !q.w_v;
  assign arready = !q.r_v;
  assign wr_fire = q.aw_v && q.w_v && !q.b_v;
  assign bvalid  = q.b_v;
  assign bresp   = q.b_r;
  assign rvalid  = q.r_v;
  assign rdata   = q.r_d;
  assign rresp   = q.r_r;
  assign rif.wr_stb  = wr_fire;
  assign rif.wr_addr = q.aw_a;
  assign rif.wr_data = q.w_d;
  assign rif.wr_strb = q.w_s;
  assign rif.rd_addr = araddr;

  // channel handshakes
  always_comb begin
    d = q;
    if (awvalid && !q.aw_v) begin
      d.aw_v = 1'b1;
      d.aw_a = awaddr;
    end
    if (wvalid && !q.w_v) begin
      d.w_v = 1'b1;
      d.w_d = wdata;
      d.w_s = wstrb;
    end
    if (wr_fire) begin
      d.aw_v = 1'b0;
      d.w_v  = 1'b0;
      d.b_v  = 1'b1;
      d.b_r  = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.b_v && bready) begin
      d.b_v = 1'b0;
    end
    if (arvalid && !q.r_v) begin
      d.r_v = 1'b1;
      d.r_d = rif.rd_data;
      d.r_r = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (q.r_v && rready) begin
      d.r_v = 1'b0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

/* File: design/tcep_cap.sv */
`timescale 1ns/1ps
module tcep_cap
  import tcep_pkg::*;
#(
  parameter int N = NCH
) (
  input  wire logic           aclk,    // kernel clock
  input  wire logic           aresetn, // sync reset, low
  input  wire logic [N-1:0]   cap_in,  // raw channel inputs
  input  wire logic           trc_in,  // raw internal trigger
  input  wire logic [2*N-1:0] dir,     // direction selects
  input  wire logic [N-1:0]   en,      // capture enables
  input  wire logic [N-1:0]   pol,     // edge selects
  output      logic [N-1:0]   cap_evt, // capture pulse
  output      logic [N-1:0]   trig     // trigger level
);
  typedef struct packed {
    logic [N:0]   s1;
    logic [N:0]   s2;
    logic [N:0]   s3;
    logic [N-1:0] evt;
    logic [N-1:0] trg;
  } tcep_cps_t;

  tcep_cps_t q, d;

  assign cap_evt = q.evt;
  assign trig    = q.trg;

  // sync, pick source, detect selected edge
  always_comb begin
    int   src;
    logic cur;
    logic prv;
    logic edg;
    logic inp;
    src  = 0;
    cur  = 1'b0;
    prv  = 1'b0;
    edg  = 1'b0;
    inp  = 1'b0;
    d    = q;
    d.s1 = {trc_in, cap_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int c = 0; c < N; c++) begin
      case (dir[2*c +: 2])
        DIR_OWN:  src = c;
        DIR_PAIR: src = c ^ 1;
        default:  src = N;
      endcase
      inp = dir[2*c +: 2] != DIR_OUTPUT;
      cur = q.s2[src];
      prv = q.s3[src];
      edg = pol[c] ? (prv && !cur) : (!prv && cur);
      d.evt[c] = inp && en[c] && edg;
      d.trg[c] = inp && (cur ^ pol[c]);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rise0;
    dir[1:0] == DIR_OWN && en[0] && !pol[0] && q.s2[0] && !q.s3[0];
  endsequence
  sequence s_fall0;
    dir[1:0] == DIR_OWN && en[0] && pol[0] && !q.s2[0] && q.s3[0];
  endsequence
  property p_cap_edge;
    s_rise0 or s_fall0 |=> cap_evt[0];
  endproperty
  a_cap_edge: assert property (p_cap_edge)
    else $error("selected capture edge missed");
  property p_cap_off;
    !en[0] |=> !cap_evt[0];
  endproperty
  a_cap_off: assert property (p_cap_off)
    else $error("capture pulse while disabled");
endmodule

/* File: design/tcep_pkg.sv */
package tcep_pkg;
  localparam int NCH   = 6;
  localparam int NCOMP = 3;
  localparam int AW    = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIR_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] CEP_OFS  = 8'h20;
  // enable and polarity word
  localparam logic [31:0] CEP_RST      = 32'h0000_0000;
  localparam logic [31:0] CEP_WMASK    = 32'h0033_3fff;
  localparam logic [31:0] CEP_POL_MASK = 32'h0022_2aaa;
  localparam int CH_STRIDE = 4;
  localparam int EN_POS    = 0;
  localparam int POL_POS   = 1;
  localparam int NEN_POS   = 2;
  localparam int NPOL_POS  = 3;
  // control word
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_3f37;
  localparam int MOE_POS   = 0;
  localparam int RUN_OFFSTATE_SELECT_POS  = 1;
  localparam int IDLE_OFFSTATE_SELECT_POS  = 2;
  localparam int LCK_LSB   = 4;
  localparam int IDLE_LSB  = 8;
  localparam int NIDLE_LSB = 16;
  localparam logic [1:0] LCK_L2 = 2'h2;
  // direction word, two bits a channel
  localparam logic [11:0] DIR_RST    = 12'h000;
  localparam logic [1:0]  DIR_OUTPUT = 2'h0;
  localparam logic [1:0]  DIR_OWN    = 2'h1;
  localparam logic [1:0]  DIR_PAIR   = 2'h2;
  // status word fields
  localparam int ST_NOUT_LSB = 8;
  localparam int ST_OE_LSB   = 16;
  localparam int ST_NOE_LSB  = 24;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: design/tcep_reg_if.sv */
`timescale 1ns/1ps
interface tcep_reg_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                input wr_ok, rd_data, rd_ok);
  modport core (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface

/* File: design/tcep_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module tcep_top
  import tcep_pkg::*;
(
  input  wire logic             aclk,      // kernel clock
  input  wire logic             aresetn,   // sync reset, low
  input  wire logic [AW-1:0]    awaddr,    // write address
  input  wire logic             awvalid,   // write address valid
  output      logic             awready,   // write address ready
  input  wire logic [31:0]      wdata,     // write data
  input  wire logic [3:0]       wstrb,     // byte enables
  input  wire logic             wvalid,    // write data valid
  output      logic             wready,    // write data ready
  output      logic [1:0]       bresp,     // write answer
  output      logic             bvalid,    // write answer valid
  input  wire logic             bready,    // write answer ready
  input  wire logic [AW-1:0]    araddr,    // read address
  input  wire logic             arvalid,   // read address valid
  output      logic             arready,   // read address ready
  output      logic [31:0]      rdata,     // read data
  output      logic [1:0]       rresp,     // read answer
  output      logic             rvalid,    // read data valid
  input  wire logic             rready,    // read data ready
  input  wire logic [NCH-1:0]   ref_wave,  // reference waveforms
  input  wire logic [NCH-1:0]   cap_in,    // channel input pins
  input  wire logic             trc_in,    // internal trigger
  output      logic [NCH-1:0]   main_out,  // main output levels
  output      logic [NCH-1:0]   main_oe,   // main output enables
  output      logic [NCOMP-1:0] comp_out,  // comp output levels
  output      logic [NCOMP-1:0] comp_oe,   // comp output enables
  output      logic [NCH-1:0]   cap_evt,   // capture pulses
  output      logic [NCH-1:0]   trig_out,  // trigger levels
  output      logic [2*NCH-1:0] dir_sel    // direction selects
);
  typedef struct packed {
    logic [31:0]      cep;
    logic [31:0]      ctrl;
    logic [2*NCH-1:0] dir;
    logic [NCH-1:0]   mo;
    logic [NCH-1:0]   moe;
    logic [NCOMP-1:0] co;
    logic [NCOMP-1:0] coe;
  } tcep_st_t;

  tcep_st_t     q, d;
  tcep_reg_if   rif ();
  logic [31:0]  bmask;
  logic [31:0]  status;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_pol;
  logic [1:0]   lck;
  logic         moe_b;
  logic         run_offstate_select;
  logic         idle_offstate_select;
  logic [7:0]   wa;
  logic [7:0]   ra;

  // bus slave
  tcep_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  // capture path
  tcep_cap #(.N(NCH)) u_cap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cap_in  (cap_in),
    .trc_in  (trc_in),
    .dir     (q.dir),
    .en      (ch_en),
    .pol     (ch_pol),
    .cap_evt (cap_evt),
    .trig    (trig_out)
  );

  // per channel bits and control fields
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign ch_en[c]  = q.cep[CH_STRIDE*c + EN_POS];
    assign ch_pol[c] = q.cep[CH_STRIDE*c + POL_POS];
  end

  // byte lane mask from the write strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign bmask[8*b +: 8] = {8{rif.wr_strb[b]}};
  end
  assign lck   = q.ctrl[LCK_LSB +: 2];
  assign moe_b = q.ctrl[MOE_POS];
  assign run_offstate_select  = q.ctrl[RUN_OFFSTATE_SELECT_POS];
  assign idle_offstate_select  = q.ctrl[IDLE_OFFSTATE_SELECT_POS];
  assign wa    = {rif.wr_addr[7:2], 2'b00};
  assign ra    = {rif.rd_addr[7:2], 2'b00};

  assign main_out = q.mo;
  assign main_oe  = q.moe;
  assign comp_out = q.co;
  assign comp_oe  = q.coe;
  assign dir_sel  = q.dir;

  // pin levels resolved from enables and off-state selects
  function automatic logic [3:0] resolve(
    input logic is_out, input logic en, input logic nen,
    input logic pol, input logic npol, input logic oi,
    input logic oin, input logic rf);
    logic [3:0] r;
    r = {pol, 1'b0, npol, 1'b0};
    if (!is_out) begin
      r = 4'h0;
    end else if (moe_b) begin
      if (en) begin
        r[3:2] = {rf ^ pol, 1'b1};
      end else if (run_offstate_select && nen) begin
        r[3:2] = {pol, 1'b1};
      end else begin
        r[3:2] = {run_offstate_select ? pol : 1'b0, 1'b0};
      end
      if (nen) begin
        r[1:0] = {(en ? ~rf : rf) ^ npol, 1'b1};
      end else if (run_offstate_select && en) begin
        r[1:0] = {npol, 1'b1};
      end else begin
        r[1:0] = {run_offstate_select ? npol : 1'b0, 1'b0};
      end
    end else if (idle_offstate_select && (en || nen)) begin
      r = {oi, 1'b1, oin, 1'b1};
    end
    return r;
  endfunction

  // register updates and output resolution
  always_comb begin
    logic [31:0] m;
    logic [3:0]  rs;
    logic        nen;
    logic        npol;
    logic        oin;
    m  = '0;
    rs = '0;
    nen  = 1'b0;
    npol = 1'b0;
    oin  = 1'b0;
    d = q;
    if (rif.wr_stb && wa == CEP_OFS) begin
      m = bmask & CEP_WMASK;
      if (lck >= LCK_L2) begin
        m = m & ~CEP_POL_MASK;
      end
      d.cep = (q.cep & ~m) | (rif.wr_data & m);
    end
    if (rif.wr_stb && wa == CTRL_OFS) begin
      m = bmask & CTRL_WMASK;
      d.ctrl = (q.ctrl & ~m) | (rif.wr_data & m);
    end
    for (int c = 0; c < NCH; c++) begin
      if (rif.wr_stb && wa == DIR_OFS && !ch_en[c]
          && rif.wr_strb[0 + c / 4]) begin
        d.dir[2*c +: 2] = rif.wr_data[2*c +: 2];
      end
      nen  = 1'b0;
      npol = 1'b0;
      oin  = 1'b0;
      if (c < NCOMP) begin
        nen  = q.cep[CH_STRIDE*c + NEN_POS];
        npol = q.cep[CH_STRIDE*c + NPOL_POS];
        oin  = q.ctrl[NIDLE_LSB + c];
      end
      rs = resolve(q.dir[2*c +: 2] == DIR_OUTPUT, ch_en[c], nen,
                   ch_pol[c], npol, q.ctrl[IDLE_LSB + c], oin,
                   ref_wave[c]);
      d.mo[c]  = rs[3];
      d.moe[c] = rs[2];
      if (c < NCOMP) begin
        d.co[c]  = rs[1];
        d.coe[c] = rs[0];
      end
    end
  end

  // status view of the pins
  always_comb begin
    status = '0;
    status[0 +: NCH]            = q.mo;
    status[ST_NOUT_LSB +: NCOMP] = q.co;
    status[ST_OE_LSB +: NCH]    = q.moe;
    status[ST_NOE_LSB +: NCOMP] = q.coe;
  end

  // read mux and decode
  always_comb begin
    rif.rd_ok   = 1'b1;
    rif.rd_data = '0;
    case (ra)
      CEP_OFS:  rif.rd_data = q.cep;
      CTRL_OFS: rif.rd_data = q.ctrl;
      DIR_OFS:  rif.rd_data = {20'h0_0000, q.dir};
      STAT_OFS: rif.rd_data = status;
      default:  rif.rd_ok   = 1'b0;
    endcase
    case (wa)
      CEP_OFS, CTRL_OFS, DIR_OFS, STAT_OFS: rif.wr_ok = 1'b1;
      default:                              rif.wr_ok = 1'b0;
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.cep  <= CEP_RST;
      q.ctrl <= CTRL_RST;
      q.dir  <= DIR_RST;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset;
    disable iff (1'b0) !aresetn |=> q.cep == CEP_RST && main_oe == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset left enables or drive");

  property p_unused_zero;
    (q.cep & ~CEP_WMASK) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused enable bits not zero");

  property p_store;
    rif.wr_stb && wa == CEP_OFS && rif.wr_strb == 4'hf && lck < LCK_L2
      |=> q.cep == ($past(rif.wr_data) & CEP_WMASK);
  endproperty
  a_store: assert property (p_store)
    else $error("enable word not stored");

  property p_lock;
    rif.wr_stb && wa == CEP_OFS && lck >= LCK_L2
      |=> (q.cep & CEP_POL_MASK) == $past(q.cep & CEP_POL_MASK);
  endproperty
  a_lock: assert property (p_lock)
    else $error("polarity changed under lock");

  property p_dir_hold;
    rif.wr_stb && wa == DIR_OFS && ch_en[0] |=> $stable(q.dir[1:0]);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed while enabled");

  property p_run;
    moe_b && !run_offstate_select && ch_en[0] && !q.cep[NEN_POS] && q.dir[1:0] == '0
      |=> main_oe[0] && main_out[0] == $past(ref_wave[0] ^ ch_pol[0])
          && !comp_oe[0];
  endproperty
  a_run: assert property (p_run)
    else $error("main output not ref xor polarity");

  property p_comp;
    moe_b && !run_offstate_select && !ch_en[0] && q.cep[NEN_POS] && q.dir[1:0] == '0
      |=> comp_oe[0] && !main_oe[0]
          && comp_out[0] == $past(ref_wave[0] ^ q.cep[NPOL_POS]);
  endproperty
  a_comp: assert property (p_comp)
    else $error("comp output wrong level");

  property p_off;
    moe_b && !run_offstate_select && !ch_en[1] && !q.cep[CH_STRIDE + NEN_POS]
      |=> !main_oe[1] && !comp_oe[1];
  endproperty
  a_off: assert property (p_off)
    else $error("disabled channel driven");

  property p_input_nodrive;
    q.dir[5:4] != DIR_OUTPUT |=> !main_oe[2] && !comp_oe[2];
  endproperty
  a_input_nodrive: assert property (p_input_nodrive)
    else $error("input channel driving pin");

  property p_idle_off;
    !moe_b && !idle_offstate_select |=> main_oe == '0 && comp_oe == '0;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("pin driven with outputs off");

  property p_idle_level;
    !moe_b && idle_offstate_select && ch_en[0] && q.dir[1:0] == DIR_OUTPUT
      |=> main_oe[0] && main_out[0] == $past(q.ctrl[IDLE_LSB]);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle level not driven");
endmodule

/* File: sim/tcep_pin_model.sv */
`timescale 1ns/1ps
module tcep_pin_model
  import tcep_pkg::*;
(
  input  wire logic           aclk,     // kernel clock
  output      logic [NCH-1:0] ref_wave, // reference waveforms
  output      logic [NCH-1:0] cap_in,   // channel input pins
  output      logic           trc_in    // internal trigger
);
  // quiet pins until the bench asks for activity
  initial begin
    ref_wave = '0;
    cap_in   = '0;
    trc_in   = 1'b0;
  end

  // new pin levels land just after a rising edge, never on it
  task automatic drive(input logic [NCH-1:0] r, input logic [NCH-1:0] c);
    @(posedge aclk);
    ref_wave <= r;
    cap_in   <= c;
  endtask
endmodule

/* File: sim/test_timer_channel_enable_polarity.sv */
`timescale 1ns/1ps
module test_timer_channel_enable_polarity
  import tcep_pkg::*;
;
  logic             aclk, aresetn, awvalid, awready, wvalid, wready;
  logic             bvalid, bready, arvalid, arready, rvalid, rready;
  logic [AW-1:0]    awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp;
  logic [NCH-1:0]   ref_wave, cap_in, main_out, main_oe, cap_evt, trig_out;
  logic             trc_in;
  logic [NCOMP-1:0] comp_out, comp_oe;
  logic [2*NCH-1:0] dir_sel;
  int               miscompares, samples_checked, n;
  logic [31:0]      v;
  localparam logic [31:0] ENS = CEP_WMASK & ~CEP_POL_MASK;
  // lock table: control word, written word, expected word
  localparam logic [31:0] LK [5][3] = '{
    '{32'h0000_0000, CEP_WMASK,     CEP_WMASK},
    '{32'h0000_0030, ENS,           CEP_WMASK},
    '{32'h0000_0000, ENS,           ENS},
    '{32'h0000_0020, CEP_WMASK,     ENS},
    '{32'h0000_0010, CEP_WMASK,     CEP_WMASK}};
  // ch1 pin table: control, word, {ref, main, main oe, comp, comp oe}
  localparam logic [31:0] OT [8][3] = '{
    '{32'h0000_0001, 32'h0000_0004, 32'h0000_0013},
    '{32'h0000_0001, 32'h0000_000c, 32'h0000_0011},
    '{32'h0000_0001, 32'h0000_0005, 32'h0000_0007},
    '{32'h0000_0001, 32'h0000_000f, 32'h0000_000d},
    '{32'h0000_0003, 32'h0000_0001, 32'h0000_001d},
    '{32'h0000_0003, 32'h0000_0009, 32'h0000_001f},
    '{32'h0000_0000, 32'h0000_0003, 32'h0000_0018},
    '{32'h0000_0104, 32'h0000_0001, 32'h0000_001d}};
  // capture table: word, pin level, pulses, trigger level
  localparam logic [31:0] CP [5][4] = '{
    '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001},
    '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
    '{32'h0000_0003, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000},
    '{32'h0000_0003, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001},
    '{32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000}};

  tcep_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ref_wave(ref_wave),
    .cap_in(cap_in), .trc_in(trc_in), .main_out(main_out),
    .main_oe(main_oe), .comp_out(comp_out), .comp_oe(comp_oe),
    .cap_evt(cap_evt), .trig_out(trig_out), .dir_sel(dir_sel));

  tcep_pin_model pins_u (
    .aclk(aclk), .ref_wave(ref_wave), .cap_in(cap_in), .trc_in(trc_in));

  // 25 MHz kernel clock
  always #20 aclk = ~aclk;

  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp,
                          input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk_resp("write answer", er, bresp);
  endtask

  // one read, compared against the expected word and answer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er, input string what);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(what, exp, rdata);
    chk_resp("read answer", er, rresp);
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state of word and pins
    rd_chk(CEP_OFS, CEP_RST, RESP_OKAY, "word at reset");
    chk("enables at reset", '0, 32'({main_oe, comp_oe, cap_evt}));
    // every writable bit, polarity always with its channel enable
    for (int i = 0; i < 32; i++) begin
      if (CEP_WMASK[i]) begin
        v = (32'h0000_0001 << i) | (32'h0000_0001 << (i - i % 4));
        wr(CEP_OFS, v, RESP_OKAY);
        rd_chk(CEP_OFS, v, RESP_OKAY, "word bit");
      end
    end
    // polarity bits frozen at lock levels 3 and 2 only
    for (int k = 0; k < 5; k++) begin
      wr(CTRL_OFS, LK[k][0], RESP_OKAY);
      wr(CEP_OFS, LK[k][1], RESP_OKAY);
      rd_chk(CEP_OFS, LK[k][2], RESP_OKAY, "lock");
    end
    wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    // each channel main output, both polarities, against ref
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    for (int c = 0; c < NCH; c++) begin
      for (int p = 0; p < 2; p++) begin
        wr(CEP_OFS, 32'(1 + 2 * p) << (4 * c), RESP_OKAY);
        pins_u.drive(p ? '0 : '1, '0);
        repeat (2) @(posedge aclk);
        chk("main enables", 32'(1) << c, 32'(main_oe));
        chk("main levels", 32'(1) << c, 32'(main_out));
      end
    end
    // ch1 main and complementary levels across off-state controls
    for (int k = 0; k < 8; k++) begin
      wr(CTRL_OFS, OT[k][0], RESP_OKAY);
      wr(CEP_OFS, OT[k][1], RESP_OKAY);
      pins_u.drive({NCH{OT[k][2][4]}}, '0);
      repeat (2) @(posedge aclk);
      v = 32'({main_out[0], main_oe[0], comp_out[0], comp_oe[0]});
      chk("ch1 pins", 32'(OT[k][2][3:0]), v);
    end
    // direction select frozen while the channel is enabled
    wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    wr(CEP_OFS, 32'h0000_0001, RESP_OKAY);
    wr(DIR_OFS, 32'h0000_0011, RESP_OKAY);
    rd_chk(DIR_OFS, 32'h0000_0010, RESP_OKAY, "dir while on");
    wr(CEP_OFS, 32'h0000_0000, RESP_OKAY);
    wr(DIR_OFS, 32'h0000_0011, RESP_OKAY);
    rd_chk(DIR_OFS, 32'h0000_0011, RESP_OKAY, "dir while off");
    chk("dir pins", 32'h0000_0011, 32'(dir_sel));
    // ch1 capture edges and trigger level
    for (int k = 0; k < 5; k++) begin
      wr(CEP_OFS, CP[k][0], RESP_OKAY);
      pins_u.drive('0, NCH'(CP[k][1]));
      n = 0;
      repeat (8) begin
        @(posedge aclk);
        if (cap_evt !== '0) n++;
      end
      chk("capture pulses", CP[k][2], 32'(n));
      if (CP[k][0][0]) chk("trigger", CP[k][3], 32'(trig_out[0]));
    end
    // ch2 on pair pin, ch3 own pin, ch4 on trigger; none may drive
    wr(DIR_OFS, 32'h0000_00d9, RESP_OKAY);
    chk("dir pins", 32'h0000_00d9, 32'(dir_sel));
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    wr(CEP_OFS, 32'h0000_3130, RESP_OKAY);
    pins_u.drive('0, '0);
    n = 0;
    repeat (8) begin
      @(posedge aclk);
      if (32'(cap_evt) === 32'h0000_0002) n++;
    end
    chk("pair capture", 32'h0000_0001, 32'(n));
    chk("trigger levels", 32'h0000_000a, 32'(trig_out));
    chk("input drive", '0, 32'({main_oe, comp_oe}));
    // unmapped offset and read-only status
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR, "unmapped read");
    wr(STAT_OFS, 32'h0000_0000, RESP_OKAY);
    conclude();
  end
endmodule
